// ==== verilog/step_interpolator_standstill_diag.sv ====
// Step/direction interpolator with standstill detection and two diagnostic pins.
// Assumes step and direction are synchronous-sampled pins from an external controller.
// What this block does
// - Emit microsteps at 256 resolution per edge
// - Measure last period, split into microsteps
// - Each pulse gives 1 to 256 microsteps
// - Interpolate only when interpEnable set
// - Longest microstep interval is 2^20 clocks
// - Short idle detect uses 2^18 clocks
// - Set idleFlag on standstill timeout
// - Clear idleFlag on next active edge
// - Standstill selects hold current level
// - Adopt new rate after one period
// - Selectable source and drive type per pin
// - diag_out_zero low during reset
// - Stall result as a diagnostic source
// - Index while microstep counter is zero
// - Index lasts for the zero microstep
// - Chopper on-state alternating between coils
// - Skipped-step source toggles per skipped step
// - Motion mode shows compare and interrupt
// - Reset sets position reached event
// - Dual edge counts both step edges
// - Direction 0 counts up, 1 counts down
`timescale 1ns/1ps
module step_interpolator_standstill_diag
    import step_interp_pkg::*;
#(
    parameter int IDLE_LONG  = IDLE_LONG_CLKS,
    parameter int IDLE_SHORT = IDLE_SHORT_CLKS
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                clkEn,
    input  wire logic                stepPulseIn,
    input  wire logic                directionIn,
    input  wire chopper_config_reg_t chopperConfig,
    input  wire global_config_reg_t  globalConfig,
    input  wire diag_sources_t       diagSources,
    input  wire logic [7:0]          runCurrentLevel,
    input  wire logic [7:0]          holdCurrentLevel,
    output logic [9:0]               microstepCounter,
    output logic                     microstepPulse,
    output logic                     idleFlag,
    output logic [7:0]               currentTarget,
    output logic                     resetSeen,
    output logic                     diagOutZero,
    output logic                     diagOutZeroOe,
    output logic                     diagOutOne,
    output logic                     diagOutOneOe
);
    // ==========================================================
    // Input synchronisers and edge detect
    logic [2:0] stepSyncFf, nxtStepSync;
    logic [1:0] dirSyncFf, nxtDirSync;
    logic       activeEdge;

    always_comb begin
        nxtStepSync = {stepSyncFf[1:0], stepPulseIn};
        nxtDirSync  = {dirSyncFf[0], directionIn};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stepSyncFf <= 3'h0;
            dirSyncFf  <= 2'h0;
        end else if (clkEn) begin
            stepSyncFf <= nxtStepSync;
            dirSyncFf  <= nxtDirSync;
        end
    end

    always_comb begin
        if (chopperConfig.dualEdgeStep)
            activeEdge = stepSyncFf[2] ^ stepSyncFf[1];
        else
            activeEdge = stepSyncFf[1] & ~stepSyncFf[2];
    end

    // ==========================================================
    // Period measurement, standstill timer and interpolation
    logic [PERIOD_W-1:0] periodCntFf, nxtPeriodCnt;
    logic [PERIOD_W-1:0] lastPeriodFf, nxtLastPeriod;
    logic [PERIOD_W-1:0] subCntFf, nxtSubCnt;
    logic [PERIOD_W-1:0] subInterval;
    logic [8:0]          remainFf, nxtRemain;
    logic [9:0]          microstepFf, nxtMicrostep;
    logic                dirFf, nxtDir;
    logic                idleFf, nxtIdle;
    logic                pulseFf, nxtPulse;
    logic                skipToggleFf, nxtSkipToggle;
    logic                chopSelFf, nxtChopSel;
    logic [8:0]          stepCount;
    logic [PERIOD_W-1:0] idleLimit;

    assign stepCount = 9'(1) << chopperConfig.resolutionLog2[3:0];
    assign idleLimit = globalConfig.shortIdleDetect ? PERIOD_W'(IDLE_SHORT)
                                                    : PERIOD_W'(IDLE_LONG);

    always_comb begin
        // Divide last period by fine steps, capped at the longest interval
        logic [PERIOD_W-1:0] raw;
        raw = lastPeriodFf >> 8;
        if (raw > PERIOD_W'(1 << MAX_SUB_LOG2))
            subInterval = PERIOD_W'(1 << MAX_SUB_LOG2);
        else if (raw == '0)
            subInterval = PERIOD_W'(1);
        else
            subInterval = raw;
    end

    always_comb begin
        nxtPeriodCnt  = periodCntFf;
        nxtLastPeriod = lastPeriodFf;
        nxtSubCnt     = subCntFf;
        nxtRemain     = remainFf;
        nxtMicrostep  = microstepFf;
        nxtDir        = dirFf;
        nxtIdle       = idleFf;
        nxtPulse      = 1'b0;
        nxtSkipToggle = skipToggleFf ^ diagSources.stepSkipped;
        nxtChopSel    = chopSelFf ^ (diagSources.chopOnA & ~diagSources.chopOnB)
                                  ^ (diagSources.chopOnB & ~diagSources.chopOnA);
        if (periodCntFf != '1)
            nxtPeriodCnt = periodCntFf + PERIOD_W'(1);
        if (periodCntFf >= idleLimit)
            nxtIdle = 1'b1;
        if (activeEdge) begin
            nxtPeriodCnt = PERIOD_W'(1);
            nxtIdle      = 1'b0;
            nxtDir       = dirSyncFf[1];
            if (idleFf)
                nxtLastPeriod = '1;
            else
                nxtLastPeriod = periodCntFf;
            if (chopperConfig.interpEnable && !idleFf && periodCntFf < (PERIOD_W'(1) << (PERIOD_W - 1))) begin
                // Outstanding microsteps of the previous step are dropped
                nxtRemain    = stepCount - 9'(1);
                nxtSubCnt    = PERIOD_W'(0);
                nxtPulse     = 1'b1;
                nxtMicrostep = dirSyncFf[1] ? microstepFf - 10'(1) : microstepFf + 10'(1);
            end else begin
                nxtRemain    = 9'h000;
                nxtPulse     = 1'b1;
                nxtMicrostep = dirSyncFf[1] ? microstepFf - 10'(stepCount)
                                            : microstepFf + 10'(stepCount);
            end
        end else if (remainFf != 9'h000) begin
            if (subCntFf + PERIOD_W'(1) >= subInterval) begin
                nxtSubCnt = PERIOD_W'(0);
                nxtRemain = remainFf - 9'(1);
                nxtPulse  = 1'b1;
                nxtMicrostep = dirFf ? microstepFf - 10'(1) : microstepFf + 10'(1);
            end else begin
                nxtSubCnt = subCntFf + PERIOD_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periodCntFf  <= '0;
            lastPeriodFf <= '1;
            subCntFf     <= '0;
            remainFf     <= 9'h000;
            microstepFf  <= MICROSTEP_RESET;
            dirFf        <= 1'b0;
            idleFf       <= 1'b0;
            pulseFf      <= 1'b0;
            skipToggleFf <= 1'b0;
            chopSelFf    <= 1'b0;
        end else if (clkEn) begin
            periodCntFf  <= nxtPeriodCnt;
            lastPeriodFf <= nxtLastPeriod;
            subCntFf     <= nxtSubCnt;
            remainFf     <= nxtRemain;
            microstepFf  <= nxtMicrostep;
            dirFf        <= nxtDir;
            idleFf       <= nxtIdle;
            pulseFf      <= nxtPulse;
            skipToggleFf <= nxtSkipToggle;
            chopSelFf    <= nxtChopSel;
        end
    end

    // ==========================================================
    // Current target and reset indication
    logic [7:0] curFf, nxtCur;
    logic       resetSeenFf, nxtResetSeen;
    logic       posReachedFf, nxtPosReached;

    always_comb begin
        nxtCur        = idleFf ? holdCurrentLevel : runCurrentLevel;
        nxtResetSeen  = resetSeenFf;
        nxtPosReached = posReachedFf & diagSources.positionReachedEvent;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            curFf        <= CUR_RESET;
            resetSeenFf  <= 1'b1;
            posReachedFf <= 1'b1;
        end else if (clkEn) begin
            curFf        <= nxtCur;
            resetSeenFf  <= nxtResetSeen;
            posReachedFf <= nxtPosReached;
        end
    end

    // ==========================================================
    // Diagnostic source selection
    logic indexActive, chopState, zeroActive, oneActive;

    assign indexActive = (microstepFf == 10'h000);
    assign chopState   = chopSelFf ? diagSources.chopOnB : diagSources.chopOnA;

    function automatic logic pickSource(input logic [2:0] sel, input logic idx,
                                        input logic chp, input logic skp,
                                        input logic stl, input logic ist);
        logic r;
        r = 1'b0;
        if (sel == DIAG_SEL_STALL)
            r = stl;
        else if (sel == DIAG_SEL_INDEX)
            r = idx;
        else if (sel == DIAG_SEL_CHOP)
            r = chp;
        else if (sel == DIAG_SEL_SKIP)
            r = skp;
        else if (sel == DIAG_SEL_STST)
            r = ist;
        return r;
    endfunction

    always_comb begin
        if (globalConfig.externalStepMode) begin
            zeroActive = pickSource(globalConfig.diagZeroSel, indexActive, chopState,
                                    skipToggleFf, diagSources.stallDetected, idleFf);
            oneActive  = pickSource(globalConfig.diagOneSel, indexActive, chopState,
                                    skipToggleFf, diagSources.stallDetected, idleFf);
        end else begin
            zeroActive = diagSources.posCompare | posReachedFf;
            oneActive  = diagSources.rampIrq;
        end
    end

    diag_pin_driver uDiagZero (
        .clk      (clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .active   (zeroActive),
        .pushPull (globalConfig.diagZeroPushPull),
        .forceLow (1'b0),
        .pinOut   (diagOutZero),
        .pinOe    (diagOutZeroOe)
    ); // Reset pulls this pin low via the driver

    diag_pin_driver uDiagOne (
        .clk      (clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .active   (oneActive),
        .pushPull (globalConfig.diagOnePushPull),
        .forceLow (1'b0),
        .pinOut   (diagOutOne),
        .pinOe    (diagOutOneOe)
    );

    assign microstepCounter = microstepFf;
    assign microstepPulse   = pulseFf;
    assign idleFlag         = idleFf;
    assign currentTarget    = curFf;
    assign resetSeen        = resetSeenFf;

    // ==========================================================
    // Assertions
    property p_idle_clear;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && activeEdge) |=> !idleFf;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle flag not cleared by step edge");

    property p_idle_set;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && !activeEdge && periodCntFf >= idleLimit) |=> idleFf;
    endproperty
    a_idle_set: assert property (p_idle_set) else $error("idle flag not set on timeout");

    property p_hold_current;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && idleFf) |=> (curFf == $past(holdCurrentLevel));
    endproperty
    a_hold_current: assert property (p_hold_current) else $error("hold current not applied");

    property p_timer_restart;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && activeEdge) |=> (periodCntFf == PERIOD_W'(1));
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");

    property p_direct_step;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && activeEdge && !chopperConfig.interpEnable && !dirSyncFf[1])
            |=> (microstepFf == $past(microstepFf) + 10'($past(stepCount)));
    endproperty
    a_direct_step: assert property (p_direct_step) else $error("direct step width wrong");

    property p_down_count;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && activeEdge && !chopperConfig.interpEnable && dirSyncFf[1])
            |=> (microstepFf == $past(microstepFf) - 10'($past(stepCount)));
    endproperty
    a_down_count: assert property (p_down_count) else $error("down count wrong");

    property p_rising_only;
        @(posedge clk) disable iff (!rst_n)
        (!chopperConfig.dualEdgeStep && stepSyncFf[2] && !stepSyncFf[1]) |-> !activeEdge;
    endproperty
    a_rising_only: assert property (p_rising_only) else $error("falling edge counted");

    property p_sub_interval;
        @(posedge clk) disable iff (!rst_n)
        subInterval <= PERIOD_W'(1 << MAX_SUB_LOG2);
    endproperty
    a_sub_interval: assert property (p_sub_interval) else $error("interval above limit");
endmodule // step_interpolator_standstill_diag

// ==== verilog/step_interp_pkg.sv ====
// Package: constants and carrier types for the step interpolator and diagnostic outputs.
// Assumes a single 100 MHz system clock.
package step_interp_pkg;
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          MSTEP_FINE      = 256;
    localparam int          PERIOD_W        = 28;
    localparam int          MAX_SUB_LOG2    = 20;
    localparam int          IDLE_LONG_LOG2  = 20;
    localparam int          IDLE_SHORT_LOG2 = 18;
    localparam int          IDLE_LONG_CLKS  = 1 << IDLE_LONG_LOG2;
    localparam int          IDLE_SHORT_CLKS = 1 << IDLE_SHORT_LOG2;
    localparam logic [9:0]  MICROSTEP_RESET = 10'h000;
    localparam logic [7:0]  CUR_RESET       = 8'h00;
    localparam logic [2:0]  DIAG_SEL_STALL  = 3'h0;
    localparam logic [2:0]  DIAG_SEL_INDEX  = 3'h1;
    localparam logic [2:0]  DIAG_SEL_CHOP   = 3'h2;
    localparam logic [2:0]  DIAG_SEL_SKIP   = 3'h3;
    localparam logic [2:0]  DIAG_SEL_STST   = 3'h4;

    typedef struct packed {
        logic       interpEnable;
        logic       dualEdgeStep;
        logic [3:0] resolutionLog2;  // 0 = 256 microsteps per full step, 8 = full step
    } chopper_config_reg_t;

    typedef struct packed {
        logic       shortIdleDetect;
        logic       externalStepMode; // 1 = step/direction, 0 = motion controller
        logic [2:0] diagZeroSel;
        logic [2:0] diagOneSel;
        logic       diagZeroPushPull;
        logic       diagOnePushPull;
    } global_config_reg_t;

    typedef struct packed {
        logic stallDetected;
        logic chopOnA;
        logic chopOnB;
        logic stepSkipped;
        logic posCompare;
        logic rampIrq;
        logic positionReachedEvent;
    } diag_sources_t;
endpackage

// ==== verilog/diag_pin_driver.sv ====
// Diagnostic pin driver: open-drain active low or push-pull active high.
// Assumes the pad resolves the wire from the output and enable.
`timescale 1ns/1ps
module diag_pin_driver
    import step_interp_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    input  wire logic active,
    input  wire logic pushPull,
    input  wire logic forceLow,
    output logic      pinOut,
    output logic      pinOe
);
    logic outFf, nxtOut, oeFf, nxtOe;

    always_comb begin
        if (forceLow) begin
            nxtOut = 1'b0;
            nxtOe  = 1'b1;
        end else if (pushPull) begin
            nxtOut = active;
            nxtOe  = 1'b1;
        end else begin
            nxtOut = 1'b0;
            nxtOe  = active;
        end
    end

    // Reset drives the pin low so the controller can see it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outFf <= 1'b0;
            oeFf  <= 1'b1;
        end else if (clkEn) begin
            outFf <= nxtOut;
            oeFf  <= nxtOe;
        end
    end

    assign pinOut = outFf;
    assign pinOe  = oeFf;
endmodule // diag_pin_driver

// ==== test/step_ctrl_model.sv ====
// Partner model: external motion controller driving the step and direction pins.
// Assumes the bench calls its tasks; pins change just after rising clk edges.
`timescale 1ns/1ps
module step_ctrl_model (
    input  wire logic clk,
    output logic      stepPin,
    output logic      dirPin
);
    initial begin
        stepPin = 1'b0;
        dirPin  = 1'b0;
    end

    // ==========
    // Step pulses
    // One full pulse in per cycles, direction set up ahead and held, near even duty
    task automatic step(input logic dir, input int per);
        @(posedge clk) dirPin <= dir;
        repeat (2) @(posedge clk);
        stepPin <= 1'b1;
        repeat (per / 2) @(posedge clk);
        stepPin <= 1'b0;
        repeat (per / 2 - 3) @(posedge clk);
    endtask

    // One level change in per cycles, for either edge mode
    task automatic toggle(input logic dir, input int per);
        @(posedge clk) dirPin <= dir;
        repeat (2) @(posedge clk);
        stepPin <= ~stepPin;
        repeat (per - 3) @(posedge clk);
    endtask
endmodule // step_ctrl_model

// ==== test/test_step_interpolator_standstill_diag.sv ====
// Testbench: drives the interpolator through the controller model and checks ports.
// Assumes short idle limits set through the design parameters.
`timescale 1ns/1ps
module test_step_interpolator_standstill_diag
    import step_interp_pkg::*;
;
    localparam int ILONG  = 4096;
    localparam int ISHORT = 1024;

    logic                clk;
    logic                rst_n;
    logic                clkEn;
    logic                stepPin;
    logic                dirPin;
    chopper_config_reg_t ccfg;
    global_config_reg_t  gcfg;
    diag_sources_t       dsrc;
    logic [7:0]          runLvl;
    logic [7:0]          holdLvl;
    logic [7:0]          curTgt;
    logic [9:0]          microstep_counter;
    logic [9:0]          base;
    logic                msPulse;
    logic                idle;
    logic                rstSeen;
    logic                d0;
    logic                d0Oe;
    logic                d1;
    logic                d1Oe;
    logic                v;
    int                  mismatches;
    int                  checksDone;
    int                  pulses;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    step_ctrl_model i_ctl (.clk(clk), .stepPin(stepPin), .dirPin(dirPin));

    step_interpolator_standstill_diag #(.IDLE_LONG(ILONG), .IDLE_SHORT(ISHORT)) i_dut (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .stepPulseIn(stepPin),
        .directionIn(dirPin), .chopperConfig(ccfg), .globalConfig(gcfg),
        .diagSources(dsrc), .runCurrentLevel(runLvl), .holdCurrentLevel(holdLvl),
        .microstepCounter(microstep_counter), .microstepPulse(msPulse), .idleFlag(idle),
        .currentTarget(curTgt), .resetSeen(rstSeen), .diagOutZero(d0),
        .diagOutZeroOe(d0Oe), .diagOutOne(d1), .diagOutOneOe(d1Oe));

    // Pulses counted on the falling clk edge, away from the rising launching edge, so the count never races it
    always @(negedge clk) begin
        if (msPulse === 1'b1)
            pulses++;
    end

    // ==========
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic closeOut();
        $display("Comparisons %0d, mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        cyc(40000);
        mismatches++;
        $display("Watchdog expired");
        closeOut();
    end

    // ==========
    // Tests
    initial begin
        rst_n = 1'b0; clkEn = 1'b1; dsrc = '0; ccfg = '0; gcfg = '0;
        runLvl = 8'h5A; holdLvl = 8'h0C; mismatches = 0; checksDone = 0; pulses = 0;
        ccfg.resolutionLog2 = 4'h8;
        gcfg.externalStepMode = 1'b1;
        gcfg.diagZeroSel = DIAG_SEL_INDEX;
        gcfg.diagOneSel = DIAG_SEL_STST;
        gcfg.diagOnePushPull = 1'b1;
        cyc(8);
        chk(d0, 1'b0);
        chk(d0Oe, 1'b1);
        chk(rstSeen, 1'b1);
        cyc(8);
        rst_n <= 1'b1;
        cyc(4);
        chk(microstep_counter, 10'h000);
        chk(d0Oe, 1'b1);
        i_ctl.step(1'b0, 40);
        chk(microstep_counter, 10'h100);
        chk(d0Oe, 1'b0);
        i_ctl.step(1'b1, 40);
        chk(microstep_counter, 10'h000);
        $display("Test direct steps done");

        ccfg.dualEdgeStep <= 1'b1;
        i_ctl.toggle(1'b0, 20);
        i_ctl.toggle(1'b0, 20);
        chk(microstep_counter, 10'h200);
        ccfg.dualEdgeStep <= 1'b0;
        i_ctl.toggle(1'b0, 20);
        i_ctl.toggle(1'b0, 20);
        chk(microstep_counter, 10'h300);
        $display("Test edge modes done");

        i_ctl.step(1'b0, 40);
        cyc(ILONG - 45);
        chk(idle, 1'b0);
        cyc(20);
        chk(idle, 1'b1);
        chk({d1Oe, d1}, 2'h3);
        chk(curTgt, holdLvl);
        i_ctl.step(1'b0, 40);
        chk(idle, 1'b0);
        chk(curTgt, runLvl);
        gcfg.shortIdleDetect <= 1'b1;
        i_ctl.step(1'b0, 40);
        cyc(ISHORT - 45);
        chk(idle, 1'b0);
        cyc(20);
        chk(idle, 1'b1);
        gcfg.shortIdleDetect <= 1'b0;
        $display("Test standstill done");

        ccfg.interpEnable <= 1'b1;
        i_ctl.step(1'b0, 1032);
        i_ctl.step(1'b0, 1032);
        base = microstep_counter;
        pulses = 0;
        i_ctl.step(1'b0, 1032);
        chk(16'(pulses), 16'h0100);
        chk(microstep_counter, 10'(base + 10'h100));
        ccfg.resolutionLog2 <= 4'h4;
        i_ctl.step(1'b0, 2048);
        i_ctl.step(1'b0, 2048);
        pulses = 0;
        i_ctl.step(1'b0, 64);
        chk(pulses < 16, 1'b1);
        pulses = 0;
        i_ctl.step(1'b0, 64);
        chk(16'(pulses), 16'h0010);
        base = microstep_counter;
        clkEn <= 1'b0;
        i_ctl.step(1'b1, 40);
        clkEn <= 1'b1;
        cyc(4);
        chk(microstep_counter, base);
        $display("Test interpolation done");

        gcfg.diagZeroSel <= DIAG_SEL_STALL;
        dsrc.stallDetected <= 1'b1;
        cyc(4);
        chk(d0Oe, 1'b1);
        dsrc.stallDetected <= 1'b0;
        cyc(4);
        chk(d0Oe, 1'b0);
        gcfg.diagOneSel <= DIAG_SEL_SKIP;
        cyc(4);
        v = d1;
        dsrc.stepSkipped <= 1'b1;
        cyc(1);
        dsrc.stepSkipped <= 1'b0;
        cyc(4);
        chk(d1, !v);
        gcfg.diagOneSel <= DIAG_SEL_CHOP;
        cyc(4);
        chk(d1, 1'b0);
        dsrc.chopOnA <= 1'b1;
        dsrc.chopOnB <= 1'b1;
        cyc(4);
        chk(d1, 1'b1);
        dsrc.chopOnA <= 1'b0;
        dsrc.chopOnB <= 1'b0;
        gcfg.diagZeroSel <= DIAG_SEL_INDEX;
        gcfg.diagZeroPushPull <= 1'b1;
        cyc(4);
        chk({d0Oe, d0}, 2'h2);
        $display("Test diag sources done");

        gcfg.externalStepMode <= 1'b0;
        dsrc.rampIrq <= 1'b1;
        dsrc.posCompare <= 1'b1;
        dsrc.positionReachedEvent <= 1'b1;
        cyc(4);
        chk(d1, 1'b1);
        chk(d0, 1'b1);
        rst_n <= 1'b0;
        cyc(3);
        chk(d0, 1'b0);
        rst_n <= 1'b1;
        dsrc.posCompare <= 1'b0;
        cyc(6);
        chk(d0, 1'b1);
        dsrc.positionReachedEvent <= 1'b0;
        cyc(4);
        chk(d0, 1'b0);
        $display("Test motion mode done");
        closeOut();
    end
endmodule // test_step_interpolator_standstill_diag
